// ### design/sbss_pkg.sv
// sbss_pkg: constants and types for the sensorless startup sequencer.
// assumes a 50 MHz system clock; shared by the sequencer and its PWM leaf.
package sbss_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PWM_PERIOD_NS = 20_000;
  localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned DUTY_W = 10;
  localparam int unsigned TIM_W = 24;
  localparam logic [DUTY_W-1:0] OPEN_DUTY_RST = 10'h100;
  localparam logic [TIM_W-1:0] OPEN_COMM_RST = 24'h030d40;
  localparam logic [TIM_W-1:0] OPEN_TIME_RST = 24'hf42400;
  localparam logic [7:0] PRELOCK_STEPS_RST = 8'h0c;
  localparam logic [TIM_W-1:0] MISS_WIN_RST = 24'h061a80;
  localparam logic [3:0] MISS_LIMIT_RST = 4'h3;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 10'h3e8;
  localparam logic [DUTY_W-1:0] DUTY_STEP = 10'h008;
  localparam logic [TIM_W-1:0] ZC_STEP = 24'h000100;
  localparam int unsigned TOL_PCT = 30;
  localparam int unsigned NUM_EDGES = 6;
  localparam int unsigned ADC_POINTS = 4;

  typedef enum logic [4:0] {
    OPEN_LOOP_START_STATE = 5'h01,
    FIRST_PRELOCK_STATE = 5'h02,
    SECOND_PRELOCK_STATE = 5'h04,
    THIRD_PRELOCK_STATE = 5'h08,
    CLOSED_LOOP_LOCKED_STATE = 5'h10
  } sbss_state_t;

  typedef struct packed {
    logic debug_on;
    logic force_locked;
    logic force_prelock1;
    logic zc_inc;
    logic zc_dec;
    logic duty_inc;
    logic duty_dec;
  } sbss_cmd_t;

  typedef struct packed {
    logic [TIM_W-1:0] open_comm;
    logic [DUTY_W-1:0] open_duty;
    logic [TIM_W-1:0] open_time;
    logic [7:0] prelock_steps;
    logic [TIM_W-1:0] miss_win;
    logic [3:0] miss_limit;
  } sbss_cfg_t;
endpackage : sbss_pkg

// ### design/sbss_pwm.sv
// sbss_pwm: fixed-period pwm carrier with duty compare.
// assumes duty is stable or changes anywhere in the period.
`timescale 1ns/10ps
module sbss_pwm
  import sbss_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // duty in, pwm out
  input wire logic [DUTY_W-1:0] duty_i,
  output logic pwm_o
);
  logic [15:0] cnt_ff;
  logic pwm_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_ff == 16'(PWM_PERIOD_CYC - 1)) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // duty counts in units of one cycle, capped by the period
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwm_ff <= 1'b0;
    end else begin
      pwm_ff <= cnt_ff < 16'(duty_i);
    end
  end

  assign pwm_o = pwm_ff;
endmodule : sbss_pwm

// ### design/sbss_seq.sv
// sbss_seq: sensorless bldc startup and lock sequencer.
// assumes comparators arrive async; commands are synchronous pulses.
// Functional notes
// RULE1 - open start: fixed duty, fixed commutation
// RULE2 - four adc triggers per commutation interval (code triggers in open start only)
// RULE3 - debug holds open start until command
// RULE4 - normal mode leaves open start after time
// RULE5 - first prelock enables comparator edge handling
// RULE6 - first prelock still commutates on schedule
// RULE7 - prelock one ends after programmed steps
// RULE8 - second prelock timestamps edges, averages them
// RULE9 - average revolution within 30% of six steps
// RULE10 - third prelock waits scheduled step, locks
// RULE11 - locked duty from pi speed controller
// RULE12 - locked commutation delay from edge timestamps
// RULE13 - missing edge forces emergency commutation
// RULE14 - repeated misses fall back to open start
// RULE15 - miss window and miss limit programmable
// RULE16 - no ramp state, single fixed setting
// RULE17 - edges ignored during open start
// RULE18 - debug mode: transitions on commands only
// RULE19 - start-up duty, delay adjustable by command
`timescale 1ns/10ps
module sbss_seq
  import sbss_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // comparators and speed target
  input wire logic [2:0] back_emf_comparator_i,
  input wire logic [DUTY_W-1:0] speed_target_i,
  // control
  input wire logic run_i,
  input wire sbss_cmd_t cmd_i,
  input wire sbss_cfg_t cfg_i,
  // driver side
  output logic pwm_o,
  output logic [2:0] comm_step_o,
  output logic comm_pulse_o,
  output logic adc_trig_o,
  output logic emergency_o,
  // status
  output sbss_state_t state_o,
  output logic [DUTY_W-1:0] duty_o,
  output logic [TIM_W-1:0] rev_avg_o
);
  sbss_state_t state_ff, nxt_state;
  logic [2:0] cmp_s1_ff, cmp_s2_ff, cmp_d_ff;
  logic [TIM_W-1:0] tmr_ff, ts_ff, zc_ff, rev_ff, open_comm_ff, edge_tmr_ff;
  logic [TIM_W-1:0] since_edge_ff, buf_ff [NUM_EDGES];
  logic [2:0] wr_ff, step_ff;
  logic [7:0] steps_ff;
  logic [3:0] miss_ff;
  logic [DUTY_W-1:0] duty_ff, open_duty_ff;
  logic [TIM_W+3:0] integ_ff;
  logic [1:0] adc_q_ff;
  logic sched, edge_seen, pending_ff, emerg, fill_ff, emerg_ff;
  logic [TIM_W+2:0] sum;

  function automatic logic [2:0] wrap6(input logic [2:0] v);
    wrap6 = (v == 3'h5) ? 3'h0 : v + 3'h1;
  endfunction : wrap6

  // two-flop synchroniser; only the second stage feeds edge logic
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmp_s1_ff <= 3'h0;
      cmp_s2_ff <= 3'h0;
      cmp_d_ff <= 3'h0;
    end else begin
      cmp_s1_ff <= back_emf_comparator_i;
      cmp_s2_ff <= cmp_s1_ff;
      cmp_d_ff <= cmp_s2_ff;
    end
  end

  // both edges, gated off in open start [RULE5] [RULE17]
  assign edge_seen = run_i && (state_ff != OPEN_LOOP_START_STATE) &&
                     (cmp_s2_ff != cmp_d_ff);

  // scheduled step: open period before lock, edge delay when locked
  assign sched = (state_ff == CLOSED_LOOP_LOCKED_STATE) ?
                 (pending_ff && tmr_ff >= zc_ff) :                // [RULE12]
                 // plus one so the open period is exactly open_comm cycles
                 (run_i && tmr_ff + 24'h000001 >= open_comm_ff);   // [RULE1] [RULE6]
  assign emerg = run_i && (state_ff == CLOSED_LOOP_LOCKED_STATE) &&
                 !edge_seen && since_edge_ff >= cfg_i.miss_win;  // [RULE13] [RULE15]

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tmr_ff <= '0;
      step_ff <= 3'h0;
      pending_ff <= 1'b0;
    end else if (sched || emerg || !run_i) begin
      tmr_ff <= '0;
      step_ff <= run_i ? wrap6(step_ff) : step_ff;
      // an edge in the step cycle itself is kept for the next step
      pending_ff <= edge_seen;
    end else begin
      tmr_ff <= tmr_ff + 1'b1;
      pending_ff <= pending_ff | edge_seen;
    end
  end

  // four adc points per commutation interval, in open start only [RULE2]
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adc_q_ff <= 2'h0;
      adc_trig_o <= 1'b0;
    end else if (sched || !run_i) begin
      adc_q_ff <= 2'h0;
      adc_trig_o <= 1'b0;
    end else begin
      adc_trig_o <= state_ff == OPEN_LOOP_START_STATE &&
                    tmr_ff == (open_comm_ff >> 2) * TIM_W'(adc_q_ff);
      if (tmr_ff == (open_comm_ff >> 2) * TIM_W'(adc_q_ff)) begin
        adc_q_ff <= adc_q_ff + 2'h1;
      end
    end
  end

  // edge timestamps into a ring, running sum of one revolution [RULE8]
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ts_ff <= '0;
      wr_ff <= 3'h0;
      fill_ff <= 1'b0;
      for (int i = 0; i < NUM_EDGES; i++) buf_ff[i] <= '0;
    end else if (!edge_seen) begin
      ts_ff <= ts_ff + 1'b1;
    end else if (state_ff != FIRST_PRELOCK_STATE) begin
      buf_ff[wr_ff] <= ts_ff;
      ts_ff <= '0;
      wr_ff <= wrap6(wr_ff);
      fill_ff <= fill_ff | (wr_ff == 3'h5);
    end else begin
      ts_ff <= '0;
    end
  end

  always_comb begin
    sum = '0;
    for (int i = 0; i < NUM_EDGES; i++) sum = sum + (TIM_W+3)'(buf_ff[i]);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rev_ff <= '0;
    end else begin
      rev_ff <= sum[TIM_W-1:0];
    end
  end

  // start-up tuning by command, auto delay only when locked [RULE19]
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      open_comm_ff <= OPEN_COMM_RST;
      open_duty_ff <= OPEN_DUTY_RST;
      zc_ff <= '0;
    end else if (state_ff == CLOSED_LOOP_LOCKED_STATE) begin
      if (edge_seen) zc_ff <= rev_ff / TIM_W'(NUM_EDGES * 2);       // [RULE12]
    end else if (!run_i) begin
      open_comm_ff <= cfg_i.open_comm;                              // [RULE16]
      open_duty_ff <= cfg_i.open_duty;
    end else begin
      if (cmd_i.zc_inc) open_comm_ff <= open_comm_ff + ZC_STEP;
      else if (cmd_i.zc_dec && open_comm_ff > ZC_STEP)
        open_comm_ff <= open_comm_ff - ZC_STEP;
      if (cmd_i.duty_inc && open_duty_ff < DUTY_MAX)
        open_duty_ff <= open_duty_ff + DUTY_STEP;
      else if (cmd_i.duty_dec && open_duty_ff > DUTY_STEP)
        open_duty_ff <= open_duty_ff - DUTY_STEP;
    end
  end

  // pi speed loop on the revolution average; fixed duty before lock
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      duty_ff <= OPEN_DUTY_RST;
      integ_ff <= '0;
    end else if (state_ff != CLOSED_LOOP_LOCKED_STATE) begin
      duty_ff <= open_duty_ff;                                      // [RULE1]
      integ_ff <= (TIM_W+4)'(open_duty_ff);
    end else if (edge_seen) begin
      // speed error: target minus measured revolution time in units of 2^14 cycles
      integ_ff <= integ_ff + (TIM_W+4)'(speed_target_i) -
                  (TIM_W+4)'(rev_ff[TIM_W-1:14]);                    // [RULE11]
      duty_ff <= (integ_ff[TIM_W+3:DUTY_W] != '0) ? DUTY_MAX :
                 integ_ff[DUTY_W-1:0] + (speed_target_i >> 2);       // [RULE11]
    end
  end

  // missed-edge counting
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      since_edge_ff <= '0;
      miss_ff <= 4'h0;
      emerg_ff <= 1'b0;
    end else begin
      emerg_ff <= emerg;
      if (edge_seen || state_ff != CLOSED_LOOP_LOCKED_STATE) begin
        since_edge_ff <= '0;
        miss_ff <= 4'h0;
      end else if (emerg) begin
        since_edge_ff <= '0;
        miss_ff <= miss_ff + 4'h1;
      end else begin
        since_edge_ff <= since_edge_ff + 1'b1;
      end
    end
  end

  // state machine; debug freezes automatic moves [RULE3] [RULE18]
  always_comb begin
    nxt_state = state_ff;
    if (!run_i) begin
      nxt_state = OPEN_LOOP_START_STATE;
    end else if (cmd_i.force_locked) begin
      nxt_state = CLOSED_LOOP_LOCKED_STATE;
    end else if (cmd_i.force_prelock1) begin
      nxt_state = FIRST_PRELOCK_STATE;
    end else if (!cmd_i.debug_on) begin
      unique case (state_ff)
        OPEN_LOOP_START_STATE:
          if (edge_tmr_ff >= cfg_i.open_time) nxt_state = FIRST_PRELOCK_STATE; // [RULE4]
        FIRST_PRELOCK_STATE:
          if (steps_ff >= cfg_i.prelock_steps) nxt_state = SECOND_PRELOCK_STATE; // [RULE7]
        SECOND_PRELOCK_STATE:
          if (fill_ff && (rev_ff * 24'd10 >= open_comm_ff * 24'd42) &&
              (rev_ff * 24'd10 <= open_comm_ff * 24'd78))
            nxt_state = THIRD_PRELOCK_STATE;                          // [RULE9]
        THIRD_PRELOCK_STATE:
          if (sched) nxt_state = CLOSED_LOOP_LOCKED_STATE;             // [RULE10]
        CLOSED_LOOP_LOCKED_STATE:
          if (emerg && miss_ff + 4'h1 >= cfg_i.miss_limit)
            nxt_state = OPEN_LOOP_START_STATE;                         // [RULE14]
        default: nxt_state = OPEN_LOOP_START_STATE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= OPEN_LOOP_START_STATE;
      edge_tmr_ff <= '0;
      steps_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      // idle time with run_i low must not count toward the open duration
      edge_tmr_ff <= (nxt_state != state_ff || !run_i) ? '0 :
                     edge_tmr_ff + 1'b1;
      steps_ff <= (nxt_state != state_ff || !run_i) ? 8'h00 :
                  steps_ff + {7'h00, sched && steps_ff != 8'hff};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      comm_pulse_o <= 1'b0;
    end else begin
      comm_pulse_o <= run_i && (sched || emerg);
    end
  end

  sbss_pwm u_pwm (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .duty_i(duty_ff),
    .pwm_o(pwm_o)
  );

  assign comm_step_o = step_ff;
  assign emergency_o = emerg_ff;
  assign state_o = state_ff;
  assign duty_o = duty_ff;
  assign rev_avg_o = rev_ff;

  a_open_duty_fix: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_ff == OPEN_LOOP_START_STATE |=> duty_ff == $past(open_duty_ff))
    else $error("open start duty not fixed"); // [RULE1]
  a_debug_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    run_i && cmd_i.debug_on && !cmd_i.force_locked && !cmd_i.force_prelock1
    |=> state_ff == $past(state_ff))
    else $error("state moved in debug"); // [RULE3]
  a_open_no_edge: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_ff == OPEN_LOOP_START_STATE |-> !edge_seen)
    else $error("edge taken in open start"); // [RULE17]
  a_emerg_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
    emerg |=> comm_pulse_o && emergency_o)
    else $error("emergency step not issued"); // [RULE13]
  a_lock_path: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_ff == THIRD_PRELOCK_STATE && sched && run_i && !cmd_i.debug_on &&
    !cmd_i.force_prelock1 |=> state_ff == CLOSED_LOOP_LOCKED_STATE)
    else $error("third prelock did not lock"); // [RULE10]
  a_p1_no_buf: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_ff == FIRST_PRELOCK_STATE |=> wr_ff == $past(wr_ff))
    else $error("buffer written in first prelock"); // [RULE8]
  a_auto_leave: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_ff == OPEN_LOOP_START_STATE && run_i && !cmd_i.debug_on &&
    !cmd_i.force_locked && edge_tmr_ff >= cfg_i.open_time
    |=> state_ff == FIRST_PRELOCK_STATE)
    else $error("open start did not time out"); // [RULE4]
  a_fall_back: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_ff == CLOSED_LOOP_LOCKED_STATE && emerg && !cmd_i.debug_on &&
    !cmd_i.force_locked && !cmd_i.force_prelock1 &&
    miss_ff + 4'h1 >= cfg_i.miss_limit |=> state_ff == OPEN_LOOP_START_STATE)
    else $error("no fall back after misses"); // [RULE14]
endmodule : sbss_seq

// ### verif/sbss_drv_model.sv
// sbss_drv_model: gate driver with back-emf comparators behind the sequencer.
// assumes one commutation pulse per step; silent_i mimics a stalled rotor.
`timescale 1ns/10ps
module sbss_drv_model #(
  parameter int DLY = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // from the sequencer
  input wire logic comm_pulse_i,
  input wire logic [2:0] comm_step_i,
  input wire logic silent_i,
  // comparator levels
  output logic [2:0] back_emf_comparator_o
);
  int cnt_ff;
  logic [1:0] ph_ff;
  // each step moves one phase; six steps give six edges a revolution
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 0;
      ph_ff <= 2'h0;
      back_emf_comparator_o <= 3'h0;
    end else if (comm_pulse_i && !silent_i) begin
      cnt_ff <= DLY;
      ph_ff <= 2'(comm_step_i % 3);
    end else if (cnt_ff == 1) begin
      cnt_ff <= 0;
      back_emf_comparator_o[ph_ff] <= ~back_emf_comparator_o[ph_ff];
    end else if (cnt_ff > 1) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
endmodule : sbss_drv_model

// ### verif/sbss_seq_test.sv
// sbss_seq_test: self-checking bench for the startup sequencer.
// assumes short cfg counts so the whole run stays near 10k cycles.
`timescale 1ns/10ps
module sbss_seq_test;
  import sbss_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] cmp;
  logic [DUTY_W-1:0] speed_target_i = 10'h200;
  logic run_i = 1'b0;
  logic silent = 1'b0;
  sbss_cmd_t cmd_i = '0;
  sbss_cfg_t cfg_i;
  logic pwm_o, comm_pulse_o, adc_trig_o, emergency_o;
  logic [2:0] comm_step_o;
  sbss_state_t state_o;
  logic [DUTY_W-1:0] duty_o;
  logic [TIM_W-1:0] rev_avg_o;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  initial begin
    cfg_i.open_comm = 24'h000064;
    cfg_i.open_duty = 10'h100;
    cfg_i.open_time = 24'h0007d0;
    cfg_i.prelock_steps = 8'h04;
    cfg_i.miss_win = 24'h00012c;
    cfg_i.miss_limit = 4'h3;
  end
  always #10 clk_i = ~clk_i;
  sbss_seq sbss_seq_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .back_emf_comparator_i(cmp), .speed_target_i(speed_target_i),
    .run_i(run_i), .cmd_i(cmd_i), .cfg_i(cfg_i), .pwm_o(pwm_o),
    .comm_step_o(comm_step_o), .comm_pulse_o(comm_pulse_o),
    .adc_trig_o(adc_trig_o), .emergency_o(emergency_o),
    .state_o(state_o), .duty_o(duty_o), .rev_avg_o(rev_avg_o));
  sbss_drv_model sbss_drv_model_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .comm_pulse_i(comm_pulse_o), .comm_step_i(comm_step_o),
    .silent_i(silent), .back_emf_comparator_o(cmp));
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // steps one edge, then samples once the edge's updates have landed
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick
  // n returns the cycles spent; the caller judges the bound
  task automatic wait_state(input sbss_state_t s, input int lim);
    n = 0;
    while (state_o !== s && n < lim) begin
      tick();
      n++;
    end
  endtask : wait_state
  task automatic wait_comm(input int lim);
    n = 0;
    while (comm_pulse_o !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
  endtask : wait_comm
  task automatic t_open_debug;
    int a;
    @(posedge clk_i);
    cmd_i.debug_on <= 1'b1;
    run_i <= 1'b1;
    wait_comm(300);
    check("comm step", 32'd1, comm_step_o);
    tick();
    a = 0;
    n = 1;
    while (comm_pulse_o !== 1'b1 && n < 300) begin
      if (adc_trig_o === 1'b1) a++;
      tick();
      n++;
    end
    check("open period", 32'd100, n);
    check("adc triggers", 32'd4, a + (adc_trig_o === 1'b1));
    check("open duty", 32'h100, duty_o);
    a = 0;
    repeat (1000) begin
      if (pwm_o === 1'b1) a++;
      tick();
    end
    check("pwm high", 32'd256, a);
    repeat (2000) tick();
    check("debug hold", OPEN_LOOP_START_STATE, state_o);
    @(posedge clk_i);
    cmd_i.duty_inc <= 1'b1;
    @(posedge clk_i);
    cmd_i.duty_inc <= 1'b0;
    repeat (3) tick();
    check("duty step", 32'h108, duty_o);
    @(posedge clk_i);
    cmd_i.force_prelock1 <= 1'b1;
    @(posedge clk_i);
    cmd_i.force_prelock1 <= 1'b0;
    #1;
    check("force prelock", FIRST_PRELOCK_STATE, state_o);
    @(posedge clk_i);
    cmd_i.debug_on <= 1'b0;
    run_i <= 1'b0;
    repeat (4) tick();
    check("stop state", OPEN_LOOP_START_STATE, state_o);
  endtask : t_open_debug
  task automatic t_lock_seq;
    @(posedge clk_i);
    run_i <= 1'b1;
    wait_state(FIRST_PRELOCK_STATE, 2500);
    check("open time", 1, n >= 1995 && n <= 2005);
    wait_state(SECOND_PRELOCK_STATE, 600);
    check("prelock steps", 1, n >= 250 && n <= 410);
    wait_state(THIRD_PRELOCK_STATE, 2000);
    check("rev match", THIRD_PRELOCK_STATE, state_o);
    check("rev window", 1, rev_avg_o >= 420 && rev_avg_o <= 780);
    wait_state(CLOSED_LOOP_LOCKED_STATE, 150);
    check("lock", CLOSED_LOOP_LOCKED_STATE, state_o);
    check("lock on step", 1, comm_pulse_o === 1'b1 || n <= 2);
    repeat (3000) tick();
    check("locked hold", CLOSED_LOOP_LOCKED_STATE, state_o);
    check("pi duty", 1, duty_o !== 10'h100);
    wait_comm(300);
    check("locked step", 1'b1, comm_pulse_o);
  endtask : t_lock_seq
  task automatic t_miss;
    @(posedge clk_i);
    silent <= 1'b1;
    n = 0;
    while (emergency_o !== 1'b1 && n < 700) begin
      tick();
      n++;
    end
    check("emergency", 1'b1, emergency_o);
    wait_state(OPEN_LOOP_START_STATE, 1500);
    check("fall back", OPEN_LOOP_START_STATE, state_o);
    @(posedge clk_i);
    silent <= 1'b0;
    run_i <= 1'b0;
  endtask : t_miss
  // a hang anywhere counts as a failure
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    tick();
    check("reset state", OPEN_LOOP_START_STATE, state_o);
    check("reset duty", 32'h100, duty_o);
    t_open_debug();
    t_lock_seq();
    t_miss();
    summarize();
  end
endmodule : sbss_seq_test
